// ### csc_pkg.sv
// csc_pkg: register map, field positions, reset values and timing counts
// for the capacitive sensing control block; shared by all design files.
package csc_pkg;

  // register indices on the plain register port
  localparam logic [1:0] CSC_ADDR_CTRL0 = 2'h0;  // control register 0
  localparam logic [1:0] CSC_ADDR_CTRL1 = 2'h1;  // channel select register
  localparam logic [1:0] CSC_ADDR_STAT  = 2'h2;  // read-only live status

  // control register 0 field positions
  localparam int CSC_BIT_ENABLE = 7;
  localparam int CSC_BIT_RNG_HI = 3;
  localparam int CSC_BIT_RNG_LO = 2;
  localparam int CSC_BIT_DIR    = 1;
  localparam int CSC_BIT_T0_ROUTE = 0;

  // reset values
  localparam logic [7:0] CSC_CTRL0_RST = 8'h00;
  localparam logic [3:0] CSC_CHAN_RST  = 4'h0;

  // channel count and last legal channel code
  localparam int         CSC_NUM_CHAN  = 12;
  localparam logic [3:0] CSC_CHAN_LAST = 4'hB;

  // oscillator range encodings
  typedef enum logic [1:0] {
    CSC_RNG_OFF  = 2'h0,
    CSC_RNG_LOW  = 2'h1,
    CSC_RNG_MED  = 2'h2,
    CSC_RNG_HIGH = 2'h3
  } csc_range_t;

  // sys_clk period and half periods of the digital stand-in oscillator (ns)
  localparam int CSC_CLK_NS      = 100;
  localparam int CSC_HALF_LOW_NS = 3200;
  localparam int CSC_HALF_MED_NS = 800;
  localparam int CSC_HALF_HI_NS  = 200;
  localparam logic [5:0] CSC_HALF_LOW_CYC = 6'(CSC_HALF_LOW_NS / CSC_CLK_NS);
  localparam logic [5:0] CSC_HALF_MED_CYC = 6'(CSC_HALF_MED_NS / CSC_CLK_NS);
  localparam logic [5:0] CSC_HALF_HI_CYC  = 6'(CSC_HALF_HI_NS / CSC_CLK_NS);

endpackage : csc_pkg

// ### csc_osc.sv
// csc_osc: digital model of the sensing oscillator phase; toggles the
// source/sink direction every half period chosen by the range code.
// assumes a single sys_clk and active-low asynchronous reset.
`timescale 1ns/1ps
module csc_osc
  import csc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       run,
  input  wire logic [1:0] range,
  // oscillator phase and rising-edge pulse
  output logic            dir,
  output logic            edge_pulse
);

  logic [5:0] cnt;       // half-period counter
  logic [5:0] next_cnt;
  logic       next_dir;
  logic [5:0] half;      // current half-period length

  // pick half period from the range code
  always_comb begin
    case (range)
      CSC_RNG_LOW:  half = CSC_HALF_LOW_CYC;
      CSC_RNG_MED:  half = CSC_HALF_MED_CYC;
      CSC_RNG_HIGH: half = CSC_HALF_HI_CYC;
      default:      half = CSC_HALF_HI_CYC;
    endcase
  end

  // stopped oscillator parks in the sinking phase with no edges
  always_comb begin
    next_cnt   = cnt;
    next_dir   = dir;
    edge_pulse = 1'b0;
    if (!run) begin
      next_cnt = 6'h00;
      next_dir = 1'b0;
    end else if (cnt + 6'h01 >= half) begin
      next_cnt   = 6'h00;
      next_dir   = ~dir;
      edge_pulse = ~dir;  // rising edge of the oscillator clock
    end else begin
      next_cnt = cnt + 6'h01;
    end
  end

  // register state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 6'h00;
      dir <= 1'b0;
    end else begin
      cnt <= next_cnt;
      dir <= next_dir;
    end
  end

endmodule : csc_osc

// ### csc_mux.sv
// csc_mux: one-hot channel decoder that steers the oscillator onto a pad.
// assumes a single sys_clk and active-low asynchronous reset.
`timescale 1ns/1ps
module csc_mux
  import csc_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  // selection
  input  wire logic                    enable,
  input  wire logic [3:0]              chan,
  // registered one-hot pad select
  output logic [CSC_NUM_CHAN-1:0]      pad_sel
);

  logic [CSC_NUM_CHAN-1:0] next_sel;

  // one decoder term per channel; reserved codes match none
  genvar g;
  generate
    for (g = 0; g < CSC_NUM_CHAN; g++) begin : g_dec
      always_comb begin
        next_sel[g] = enable && (chan == 4'(g));
      end
    end
  endgenerate

  // register the select so the pad never glitches
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_sel <= '0;
    end else begin
      pad_sel <= next_sel;
    end
  end

endmodule : csc_mux

// ### csc_top.sv
// csc_top: control and status registers of the capacitive sensing block,
// with the oscillator phase model and the channel steering.
// assumes one 10 MHz sys_clk, active-low async rst_b, plain register port.
`timescale 1ns/1ps
module csc_top
  import csc_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // register port
  input  wire logic [1:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [7:0]                  reg_rdata,
  // timer0 clock selection from the timer block
  input  wire logic                   timer0_clock_source_select,
  // timer clocking, one-cycle enables
  output logic                        timer0_osc_tick,
  output logic                        osc_tick,
  // pad drive
  output logic [CSC_NUM_CHAN-1:0]     pad_sel,
  output logic                        pad_drive
);

  logic       sense_module_enable;       // control bit 7
  logic [1:0] osc_current_range;         // control bits 3:2
  logic       timer0_ext_clock_select;   // control bit 0
  logic [3:0] sense_channel_select;      // channel select register
  logic       next_enable;
  logic [1:0] next_range;
  logic       next_t0_route;
  logic [3:0] next_chan;
  logic [7:0] next_rdata;
  logic       osc_direction_status;      // live phase from the model
  logic       osc_edge;
  logic       osc_run;
  logic       next_t0_tick;
  logic       next_tick;
  logic       next_drive;

  // oscillator runs only when enabled with a nonzero range
  always_comb begin
    osc_run = sense_module_enable && (osc_current_range != CSC_RNG_OFF);
  end

  // register writes; unimplemented bits are simply not stored
  always_comb begin
    next_enable = sense_module_enable;
    next_range  = osc_current_range;
    next_t0_route = timer0_ext_clock_select;
    next_chan   = sense_channel_select;
    if (reg_wr) begin
      case (reg_addr)
        CSC_ADDR_CTRL0: begin
          next_enable = reg_wdata[CSC_BIT_ENABLE];
          next_range  = reg_wdata[CSC_BIT_RNG_HI:CSC_BIT_RNG_LO];
          next_t0_route = reg_wdata[CSC_BIT_T0_ROUTE];
        end
        CSC_ADDR_CTRL1: begin
          next_chan = reg_wdata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read data: registered, stands the cycle after the read strobe
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        CSC_ADDR_CTRL0: begin
          // bits 6-4 stay zero
          next_rdata = {sense_module_enable, 3'h0, osc_current_range,
                        osc_direction_status, timer0_ext_clock_select};
        end
        CSC_ADDR_CTRL1: begin
          next_rdata = {4'h0, sense_channel_select};
        end
        CSC_ADDR_STAT: begin
          next_rdata = {6'h00, osc_run, osc_direction_status};
        end
        default: begin
          next_rdata = 8'h00;  // unmapped reads as zero
        end
      endcase
    end
  end

  // timer clock enables and pad drive
  always_comb begin
    next_tick    = osc_edge;
    next_t0_tick = osc_edge && timer0_ext_clock_select
                   && timer0_clock_source_select;
    // a reserved channel code selects no pad, so nothing may be driven then
    next_drive   = osc_run && osc_direction_status
                   && (sense_channel_select <= CSC_CHAN_LAST);
  end

  // register all state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sense_module_enable     <= CSC_CTRL0_RST[CSC_BIT_ENABLE];
      osc_current_range       <= CSC_CTRL0_RST[CSC_BIT_RNG_HI:CSC_BIT_RNG_LO];
      timer0_ext_clock_select <= CSC_CTRL0_RST[CSC_BIT_T0_ROUTE];
      sense_channel_select    <= CSC_CHAN_RST;
      reg_rdata               <= 8'h00;
      osc_tick                <= 1'b0;
      timer0_osc_tick         <= 1'b0;
      pad_drive               <= 1'b0;
    end else begin
      sense_module_enable     <= next_enable;
      osc_current_range       <= next_range;
      timer0_ext_clock_select <= next_t0_route;
      sense_channel_select    <= next_chan;
      reg_rdata               <= next_rdata;
      osc_tick                <= next_tick;
      timer0_osc_tick         <= next_t0_tick;
      pad_drive               <= next_drive;
    end
  end

  // oscillator phase model
  csc_osc u_osc (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .run        (osc_run),
    .range      (osc_current_range),
    .dir        (osc_direction_status),
    .edge_pulse (osc_edge)
  );

  // channel steering, idle while disabled
  csc_mux u_mux (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .enable  (sense_module_enable),
    .chan    (sense_channel_select),
    .pad_sel (pad_sel)
  );

endmodule : csc_top

// ### csc_chk.sv
// csc_chk: port-level assertions for csc_top.
// assumes it is bound onto csc_top; it shadows ctrl0 from register writes.
`timescale 1ns/1ps
module csc_chk
  import csc_pkg::*;
(
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rst_b,
  // register port
  input wire logic [1:0]              reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  // timer and pad side
  input wire logic                    timer0_clock_source_select,
  input wire logic                    timer0_osc_tick,
  input wire logic                    osc_tick,
  input wire logic [CSC_NUM_CHAN-1:0] pad_sel,
  input wire logic                    pad_drive
);
  logic       en_q;   // shadow of the enable bit
  logic [1:0] rng_q;  // shadow of the range field
  logic       xcs_q;  // shadow of the timer0 route bit
  wire        rd0 = reg_rd && reg_addr == CSC_ADDR_CTRL0;  // ctrl0 read taken
  wire        off = !en_q || rng_q == 2'h0;                // oscillator must be stopped
  // shadow follows software writes only, so a stuck register shows up
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) {en_q, rng_q, xcs_q} <= 4'h0;
    else if (reg_wr && reg_addr == CSC_ADDR_CTRL0)
      {en_q, rng_q, xcs_q} <= {reg_wdata[7], reg_wdata[3:2], reg_wdata[0]};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_en_back: assert property (rd0 |=> reg_rdata[7] == $past(en_q))
    else $error("enable bit readback wrong");
  a_rsvd_zero: assert property (rd0 |=> reg_rdata[6:4] == 3'h0)
    else $error("unused ctrl0 bits not zero");
  a_rng_back: assert property (rd0 |=> reg_rdata[3:2] == $past(rng_q))
    else $error("range field readback wrong");
  a_dir_idle: assert property (rd0 && off && $past(off) |=> !reg_rdata[1])
    else $error("direction status set while stopped");
  a_xcs_back: assert property (rd0 |=> reg_rdata[0] == $past(xcs_q))
    else $error("timer0 route bit readback wrong");
  a_t0_route: assert property (timer0_osc_tick |->
    osc_tick && $past(xcs_q) && $past(timer0_clock_source_select))
    else $error("timer0 tick without route");
  a_chan_hot: assert property ($onehot0(pad_sel))
    else $error("more than one pad selected");
  a_chan_idle: assert property (!en_q && $past(!en_q) |-> pad_sel == '0)
    else $error("pad selected while disabled");
  a_drive_pad: assert property (pad_drive |-> pad_sel != '0)
    else $error("pad driven with no pad selected");
  a_quiet_off: assert property (off && $past(off) && $past(off, 2)
    |-> !osc_tick && !timer0_osc_tick && !pad_drive)
    else $error("oscillator activity while stopped");
endmodule : csc_chk

// ### csc_top_tb_top.sv
// csc_top_tb_top: directed register-port tests of csc_top.
// assumes csc_pkg, csc_top and csc_chk are compiled before this file.
`timescale 1ns/1ps
module csc_top_tb_top;
  import csc_pkg::*;
  logic                    sys_clk   = 1'h0;  // 10 MHz
  logic                    rst_b     = 1'h0;
  logic [1:0]              reg_addr  = 2'h0;
  logic [7:0]              reg_wdata = 8'h00;
  logic                    reg_wr    = 1'h0;
  logic                    reg_rd    = 1'h0;
  logic                    tcs       = 1'h0;  // timer0 clock source select
  logic [7:0]              reg_rdata, v;
  logic                    timer0_osc_tick, osc_tick, pad_drive;
  logic [CSC_NUM_CHAN-1:0] pad_sel;
  int                      fails = 0, n_compared = 0;
  int                      nt, n0, nd, e;  // tick, timer0 tick, drive counts
  csc_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer0_clock_source_select(tcs), .timer0_osc_tick(timer0_osc_tick),
    .osc_tick(osc_tick), .pad_sel(pad_sel), .pad_drive(pad_drive));
  initial forever #50 sys_clk = ~sys_clk;
  // four-state compare so an unknown never passes
  task automatic chk(input string nm, input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  // one-cycle write strobe, taken at the next edge
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask : rd
  // count pulses over a fixed window
  task automatic run(input int n);
    nt = 0;
    n0 = 0;
    nd = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      nt += int'(osc_tick === 1'h1);
      n0 += int'(timer0_osc_tick === 1'h1);
      nd += int'(pad_drive === 1'h1);
    end
  endtask : run
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // watchdog: a hang counts as a mismatch
  initial begin
    #5ms;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'h1;
    rd(CSC_ADDR_CTRL0);
    chk("ctrl0 reset", v, CSC_CTRL0_RST);
    wr(CSC_ADDR_CTRL0, 8'h73);
    rd(CSC_ADDR_CTRL0);
    chk("ctrl0 masked", v, 8'h01);
    $display("test reset and access done");
    // every range code, tick rate from the half period of each range
    for (int r = 0; r < 4; r++) begin
      wr(CSC_ADDR_CTRL0, {1'h1, 3'h0, 2'(r), 2'h0});
      rd(CSC_ADDR_CTRL0);
      chk("ctrl0 range", v & 8'hFD, 8'h80 | 8'(r << 2));
      run(128);
      // one rising oscillator edge per two half periods
      e = (r == 0) ? 0 : 128 / (2 * int'((r == 3) ? CSC_HALF_HI_CYC
          : (r == 2) ? CSC_HALF_MED_CYC : CSC_HALF_LOW_CYC));
      chk("tick rate", (nt >= e - 1 && nt <= e + 1), 1);
      chk("pad drive", nd > 0, r != 0);
      rd(CSC_ADDR_STAT);
      chk("status run", v & 8'hFE, (r != 0) ? 8'h02 : 8'h00);
    end
    $display("test ranges done");
    // timer0 gets edges only when routed and selected
    for (int k = 0; k < 4; k++) begin
      tcs <= k[1];
      wr(CSC_ADDR_CTRL0, 8'h8C | 8'(k[0]));
      run(128);
      chk("timer0 ticks", n0, (k == 3) ? nt : 0);
    end
    wr(CSC_ADDR_CTRL0, 8'h0D);
    run(64);
    chk("disabled activity", nt + n0 + nd, 0);
    $display("test timer0 route done");
    // every channel code, reserved codes select nothing
    wr(CSC_ADDR_CTRL0, 8'h80);
    for (int c = 0; c < 16; c++) begin
      wr(CSC_ADDR_CTRL1, 8'(c));
      repeat (2) @(posedge sys_clk);
      #1 chk("pad select", 16'(pad_sel), (c < CSC_NUM_CHAN) ? 16'h1 << c : 16'h0);
    end
    wr(CSC_ADDR_CTRL1, 8'h05);
    rd(CSC_ADDR_CTRL1);
    chk("chan readback", v, 8'h05);
    wr(CSC_ADDR_CTRL0, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk("pad off", 16'(pad_sel), 16'h0);
    $display("test channels done");
    print_verdict();
  end
endmodule : csc_top_tb_top
bind csc_top csc_chk chk_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .timer0_clock_source_select(timer0_clock_source_select),
  .timer0_osc_tick(timer0_osc_tick), .osc_tick(osc_tick), .pad_sel(pad_sel),
  .pad_drive(pad_drive));
